//--- hdl/sssis_top.sv
/*
 * Sleep, standby and wake sequencer of a single-wire bus transceiver,
 * with a Wishbone register file and one level interrupt.
 * Assumes mode pins and fault flags arrive asynchronously, and that the
 * wake-up detector already applied its filter delay.
 */
`include "sssis_cfg.svh"
module sssis_top #(
    parameter int unsigned SLEEP_CYCLES = `SSSIS_SLEEP_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pins and analog detectors
    input wire logic mode_select_lo_i,
    input wire logic mode_select_hi_i,
    input wire logic high_voltage_wakeup_i,
    input wire logic tx_data_low_i,
    input wire sssis_pkg::sssis_fault_t fault_i,
    // Outputs
    output sssis_pkg::sssis_drive_t drive_o,
    output logic bus_dominant_o,
    output logic irq_o
);
    import sssis_pkg::*;

    localparam logic [31:0] SLEEP_TERM = 32'(SLEEP_CYCLES - 1);

    typedef struct packed {
        logic [1:0] mode_s1;
        logic [1:0] mode_s2;
        logic wake_s1;
        logic wake_s2;
        logic [2:0] fault_s1;
        logic [2:0] fault_s2;
        logic tx_s1;
        logic tx_s2;
        sssis_state_t state;
        logic [31:0] timer;
        logic [1:0] mode_prev;
        logic rx_wake;
        logic over_temp_latch;
        logic ground_loss_latch;
        logic [`SSSIS_IRQ_BITS-1:0] irq_stat;
        logic [`SSSIS_IRQ_BITS-1:0] irq_en;
        logic [7:0] ctrl;
        logic ack;
        logic [31:0] rdata;
    } sssis_regs_t;

    sssis_regs_t r_q;
    sssis_regs_t r_d;

    function automatic logic mode_is_sleep(input logic [1:0] m);
        return m == SSSIS_M_SLEEP;
    endfunction

    function automatic sssis_mode_t decode_mode(input logic [1:0] pins);
        return sssis_mode_t'({pins[1], pins[0]} == 2'h1 ? SSSIS_M_HIGH_SPEED :
                             {pins[1], pins[0]} == 2'h2 ? SSSIS_M_HV_WAKEUP :
                             {pins[1], pins[0]} == 2'h3 ? SSSIS_M_NORMAL : SSSIS_M_SLEEP);
    endfunction

    sssis_mode_t mode;
    logic bus_req;
    logic bus_wr;
    logic bus_rd;
    logic [`SSSIS_IRQ_BITS-1:0] irq_set;
    logic mode_changed;
    logic timer_done;

    always_comb begin
        mode = decode_mode(r_q.mode_s2);
        bus_req = wb_cyc_i && wb_stb_i && !r_q.ack;
        bus_wr = bus_req && wb_we_i && wb_sel_i[0];
        bus_rd = bus_req && !wb_we_i;
        mode_changed = r_q.mode_s2 != r_q.mode_prev;
        timer_done = r_q.timer >= SLEEP_TERM;
    end

    always_comb begin
        r_d = r_q;
        irq_set = '0;
        // Mode pins and faults cross into the clock domain first.
        r_d.mode_s1 = {mode_select_hi_i, mode_select_lo_i};
        r_d.mode_s2 = r_q.mode_s1;
        r_d.wake_s1 = high_voltage_wakeup_i;
        r_d.wake_s2 = r_q.wake_s1;
        r_d.fault_s1 = fault_i;
        r_d.fault_s2 = r_q.fault_s1;
        r_d.tx_s1 = tx_data_low_i;
        r_d.tx_s2 = r_q.tx_s1;
        r_d.mode_prev = r_q.mode_s2;
        r_d.timer = r_q.timer + 32'h1;

        unique case (r_q.state)
            SSSIS_S_SLEEP: begin
                r_d.timer = '0;
                if (r_q.wake_s2) begin
                    // A wake-up restarts the power-on standby sequence.
                    r_d.state = SSSIS_S_STANDBY;
                    r_d.rx_wake = 1'b1;
                    irq_set[`SSSIS_IRQ_WAKE] = 1'b1;
                end else if (!mode_is_sleep(r_q.mode_s2)) begin
                    r_d.state = SSSIS_S_ACTIVE;
                    irq_set[`SSSIS_IRQ_MODE] = 1'b1;
                end
            end
            SSSIS_S_STANDBY: begin
                if (mode_changed && !mode_is_sleep(r_q.mode_s2)) begin
                    r_d.state = SSSIS_S_ACTIVE;
                    r_d.rx_wake = 1'b0;
                    irq_set[`SSSIS_IRQ_MODE] = 1'b1;
                end else if (mode_changed) begin
                    r_d.state = SSSIS_S_GOSLEEP;
                    r_d.timer = '0;
                end else if (timer_done) begin
                    r_d.state = SSSIS_S_SLEEP;
                    r_d.rx_wake = 1'b0;
                    irq_set[`SSSIS_IRQ_SLEEP] = 1'b1;
                end
            end
            SSSIS_S_ACTIVE: begin
                // The timer is held at zero while any active mode persists.
                r_d.timer = '0;
                if (mode_is_sleep(r_q.mode_s2)) begin
                    r_d.state = SSSIS_S_GOSLEEP;
                end
            end
            SSSIS_S_GOSLEEP: begin
                if (r_q.wake_s2) begin
                    r_d.state = SSSIS_S_STANDBY;
                    r_d.timer = '0;
                    irq_set[`SSSIS_IRQ_WAKE] = 1'b1;
                end else if (!mode_is_sleep(r_q.mode_s2)) begin
                    r_d.state = SSSIS_S_ACTIVE;
                    irq_set[`SSSIS_IRQ_MODE] = 1'b1;
                end else if (timer_done) begin
                    r_d.state = SSSIS_S_SLEEP;
                    irq_set[`SSSIS_IRQ_SLEEP] = 1'b1;
                end
            end
        endcase

        // Over-temperature latches until reset or a control bit 0 clear, ground loss until reset; undervoltage does not latch or clear them.
        if (r_q.fault_s2[2]) begin
            r_d.over_temp_latch = 1'b1;
        end
        if (r_q.fault_s2[1]) begin
            r_d.ground_loss_latch = 1'b1;
        end
        if (r_q.fault_s2[2] && !r_q.over_temp_latch) begin
            irq_set[`SSSIS_IRQ_FAULT] = 1'b1;
        end
        if (r_q.fault_s2[1] && !r_q.ground_loss_latch) begin
            irq_set[`SSSIS_IRQ_FAULT] = 1'b1;
        end

        // Register access; a set in the clearing cycle wins.
        r_d.ack = bus_req;
        r_d.rdata = '0;
        if (bus_wr && wb_adr_i == `SSSIS_ADDR_CTRL) begin
            r_d.ctrl = wb_dat_i[7:0];
        end
        if (bus_wr && wb_adr_i == `SSSIS_ADDR_IRQ_EN) begin
            r_d.irq_en = wb_dat_i[`SSSIS_IRQ_BITS-1:0];
        end
        if (bus_wr && wb_adr_i == `SSSIS_ADDR_IRQ_CLR) begin
            r_d.irq_stat = r_q.irq_stat & ~wb_dat_i[`SSSIS_IRQ_BITS-1:0];
        end
        r_d.irq_stat = r_d.irq_stat | irq_set;
        // Control bit 0 lets software clear latched over-temperature.
        if (r_q.ctrl[0] && !r_q.fault_s2[2]) begin
            r_d.over_temp_latch = 1'b0;
            r_d.ctrl[0] = 1'b0;
        end
        if (bus_rd) begin
            unique case (wb_adr_i)
                `SSSIS_ADDR_CTRL: r_d.rdata = {24'h0, r_q.ctrl};
                `SSSIS_ADDR_STATUS: r_d.rdata = {22'h0, r_q.over_temp_latch, r_q.ground_loss_latch,
                                                 r_q.fault_s2[0], r_q.rx_wake, 2'(mode), 2'(r_q.state),
                                                 r_q.mode_s2};
                `SSSIS_ADDR_IRQ_STAT: r_d.rdata = {28'h0, r_q.irq_stat};
                `SSSIS_ADDR_IRQ_EN: r_d.rdata = {28'h0, r_q.irq_en};
                default: r_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_q <= '0;
            r_q.state <= SSSIS_S_STANDBY;
            r_q.timer <= '0;
            r_q.ctrl <= `SSSIS_CTRL_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    always_comb begin
        drive_o.regulator_enable_out = r_q.state != SSSIS_S_SLEEP;
        drive_o.wave_shaping_en = mode != SSSIS_M_HIGH_SPEED;
        // Under undervoltage the transmitter stops even during ground loss.
        drive_o.bus_driver_en = !r_q.over_temp_latch && !r_q.fault_s2[0]
                                && r_q.state != SSSIS_S_SLEEP;
        drive_o.load_switch_closed = !r_q.ground_loss_latch;
        drive_o.rx_wake_low = r_q.rx_wake;
        bus_dominant_o = drive_o.bus_driver_en && r_q.tx_s2
                         && !mode_is_sleep(r_q.mode_s2);
        wb_ack_o = r_q.ack;
        wb_dat_o = r_q.rdata;
        irq_o = |(r_q.irq_stat & r_q.irq_en);
    end
endmodule

//--- hdl/sssis_cfg.svh
/*
 * Constants of the sleep/standby sequencer: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 200 MHz core clock and a 32-bit classic Wishbone slave.
 */
`ifndef SSSIS_CFG_SVH
`define SSSIS_CFG_SVH
`define SSSIS_ADDR_CTRL 8'h00
`define SSSIS_ADDR_STATUS 8'h04
`define SSSIS_ADDR_IRQ_STAT 8'h08
`define SSSIS_ADDR_IRQ_CLR 8'h0C
`define SSSIS_ADDR_IRQ_EN 8'h10
`define SSSIS_CTRL_RESET 8'h00
`define SSSIS_IRQ_BITS 4
`define SSSIS_IRQ_WAKE 0
`define SSSIS_IRQ_SLEEP 1
`define SSSIS_IRQ_MODE 2
`define SSSIS_IRQ_FAULT 3
`define SSSIS_CLK_HZ 200000000
`define SSSIS_SLEEP_MS 250
`define SSSIS_SLEEP_CYC ((`SSSIS_CLK_HZ / 1000) * `SSSIS_SLEEP_MS)
`endif

//--- hdl/sssis_pkg.sv
/*
 * Types of the sleep/standby sequencer.
 * Assumes the constants header is compiled alongside.
 */
package sssis_pkg;
    typedef enum logic [1:0] {
        SSSIS_M_SLEEP,
        SSSIS_M_HIGH_SPEED,
        SSSIS_M_HV_WAKEUP,
        SSSIS_M_NORMAL
    } sssis_mode_t;
    typedef enum logic [1:0] {
        SSSIS_S_SLEEP,
        SSSIS_S_STANDBY,
        SSSIS_S_ACTIVE,
        SSSIS_S_GOSLEEP
    } sssis_state_t;
    typedef struct packed {
        logic over_temp;
        logic ground_loss;
        logic under_voltage;
    } sssis_fault_t;
    typedef struct packed {
        logic regulator_enable_out;
        logic wave_shaping_en;
        logic bus_driver_en;
        logic load_switch_closed;
        logic rx_wake_low;
    } sssis_drive_t;
endpackage

//--- testbench/sssis_assertions.sv
/* Port checker of the sleep/standby sequencer.
   Assumes it is bound to sssis_top with the same sleep count. */
module sssis_assertions #(
    parameter int unsigned SLEEP_CYCLES = 100
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic mode_select_lo_i,
    input wire logic mode_select_hi_i,
    input wire logic high_voltage_wakeup_i,
    input wire logic bus_dominant_o,
    input wire sssis_pkg::sssis_fault_t fault_i,
    input wire sssis_pkg::sssis_drive_t drive_o
);
    import sssis_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_fast;
        mode_select_lo_i && !mode_select_hi_i;
    endsequence
    sequence s_woken;
        drive_o.regulator_enable_out && drive_o.rx_wake_low;
    endsequence
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    a_shaping_fast: assert property (s_fast [*4] |-> !drive_o.wave_shaping_en)
        else $error("shaping on in fast mode");
    a_shaping_slow: assert property (!(mode_select_lo_i && !mode_select_hi_i) [*4] |-> drive_o.wave_shaping_en)
        else $error("shaping off");
    a_sleep_quiet: assert property (!drive_o.regulator_enable_out |-> !bus_dominant_o)
        else $error("dominant while asleep");
    a_heat_off: assert property (fault_i.over_temp [*4] |-> !drive_o.bus_driver_en)
        else $error("driver on when hot");
    a_ground_open: assert property (fault_i.ground_loss [*4] |-> !drive_o.load_switch_closed)
        else $error("load closed on ground loss");
    a_wake_raise: assert property (!drive_o.regulator_enable_out && high_voltage_wakeup_i && !mode_select_lo_i
        && !mode_select_hi_i |-> ##[1:4] s_woken) else $error("wake ignored");
    a_active_hold: assert property ((mode_select_lo_i || mode_select_hi_i) [*4] |-> drive_o.regulator_enable_out)
        else $error("enable low in active mode");
endmodule
bind sssis_top sssis_assertions #(.SLEEP_CYCLES(SLEEP_CYCLES)) u_sssis_assertions (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mode_select_lo_i(mode_select_lo_i),
    .mode_select_hi_i(mode_select_hi_i), .high_voltage_wakeup_i(high_voltage_wakeup_i),
    .bus_dominant_o(bus_dominant_o), .fault_i(fault_i), .drive_o(drive_o));

//--- testbench/sssis_host_model.sv
/* Host controller model driving the mode pins.
   Assumes the bench names the wanted mode, bit 0 the low pin. */
module sssis_host_model (
    input wire logic clk_i,
    input wire logic regulator_on_i,
    input wire logic [1:0] mode_want_i,
    output logic mode_select_lo_o = 1'h0,
    output logic mode_select_hi_o = 1'h0
);
    // An unpowered host leaves the pins to their pull-downs, so it cannot leave sleep by itself.
    always @(posedge clk_i) begin
        mode_select_lo_o <= regulator_on_i & mode_want_i[0];
        mode_select_hi_o <= regulator_on_i & mode_want_i[1];
    end
endmodule

//--- testbench/sssis_top_tb.sv
/* Self-checking bench of the sleep/standby sequencer.
   Assumes a sleep count of 100 cycles so every timeout stays short. */
module sssis_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sssis_pkg::*;
    localparam int SC = 100;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc = 1'h0, stb = 1'h0, we = 1'h0, wake = 1'h0, tx = 1'h0;
    logic ack, dom, irq, lo, hi;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [1:0] want = 2'h0;
    sssis_fault_t flt = '0;
    sssis_drive_t drv;
    int fail_count = 0, checks_done = 0, cycles = 0, n;
    sssis_top #(.SLEEP_CYCLES(SC)) u_sssis_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .mode_select_lo_i(lo), .mode_select_hi_i(hi), .high_voltage_wakeup_i(wake), .tx_data_low_i(tx),
        .fault_i(flt), .drive_o(drv), .bus_dominant_o(dom), .irq_o(irq));
    sssis_host_model u_sssis_host_model (.clk_i(clk_i), .regulator_on_i(drv.regulator_enable_out),
        .mode_want_i(want), .mode_select_lo_o(lo), .mode_select_hi_o(hi));
    always #2.5 clk_i = ~clk_i;
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'h1);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
        @(posedge clk_i);
    endtask
    // The window allows for the synchroniser and host flops ahead of the timer.
    task automatic off_within(input int lo_n, input int hi_n);
        n = 0;
        while (drv.regulator_enable_out !== 1'h0 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        chk("sleep_delay", 32'(n >= lo_n && n <= hi_n), 32'h1);
    endtask
    task automatic pulse_wake();
        wake <= 1'h1;
        repeat (4) @(posedge clk_i);
        wake <= 1'h0;
        @(posedge clk_i);
    endtask
    task automatic t_timeout();
        chk("drive", drv, 32'h1E);
        tx <= 1'h1;
        off_within(SC - 2, SC + 4);
        @(posedge clk_i);
        chk("dominant", dom, 32'h0);
        pulse_wake();
        chk("woken", {drv.regulator_enable_out, drv.rx_wake_low}, 32'h3);
        off_within(SC - 6, SC + 4);
        $display("test timeout done");
    endtask
    task automatic t_irq();
        bus(1'h0, 8'h08, 32'h0);
        chk("irq_status", q[3:0], 32'h3);
        chk("irq_masked", irq, 32'h0);
        bus(1'h1, 8'h10, 32'h3);
        chk("irq_raised", irq, 32'h1);
        bus(1'h1, 8'h0C, 32'h3);
        chk("irq_cleared", irq, 32'h0);
        bus(1'h0, 8'h04, 32'h0);
        chk("state", q[3:2], 32'h0);
        bus(1'h0, 8'h40, 32'h0);
        chk("unmapped", q, 32'h0);
        $display("test irq done");
    endtask
    task automatic t_modes();
        pulse_wake();
        want <= 2'h3;
        repeat (2 * SC) @(posedge clk_i);
        chk("held_on", {drv.regulator_enable_out, dom}, 32'h3);
        for (int m = 1; m < 4; m++) begin
            want <= 2'(m);
            repeat (6) @(posedge clk_i);
            chk("shaping", drv.wave_shaping_en, 32'(m != 1));
        end
        want <= 2'h0;
        off_within(SC - 6, SC + 8);
        $display("test modes done");
    endtask
    task automatic t_faults();
        pulse_wake();
        want <= 2'h3;
        repeat (8) @(posedge clk_i);
        flt.ground_loss <= 1'h1;
        repeat (6) @(posedge clk_i);
        chk("ground_loss", {drv.bus_driver_en, drv.load_switch_closed, dom}, 32'h5);
        flt.under_voltage <= 1'h1;
        repeat (6) @(posedge clk_i);
        chk("under_voltage", {drv.bus_driver_en, dom}, 32'h0);
        flt.under_voltage <= 1'h0;
        repeat (6) @(posedge clk_i);
        chk("uv_recover", {drv.bus_driver_en, dom}, 32'h3);
        flt.over_temp <= 1'h1;
        repeat (6) @(posedge clk_i);
        chk("over_temp", {drv.bus_driver_en, dom}, 32'h0);
        flt.over_temp <= 1'h0;
        repeat (6) @(posedge clk_i);
        chk("heat_latched", drv.bus_driver_en, 32'h0);
        bus(1'h1, 8'h00, 32'h1);
        repeat (4) @(posedge clk_i);
        chk("heat_cleared", {drv.bus_driver_en, dom}, 32'h3);
        bus(1'h0, 8'h04, 32'h0);
        chk("latches", q[9:7], 32'h2);
        $display("test faults done");
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        t_timeout();
        t_irq();
        t_modes();
        t_faults();
        test_done();
    end
endmodule
